// [src/holdover_entry_exit_control.sv]
// Holdover entry and exit control with DAC tracking and an APB register file.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Multiplier code selects 4, 64, 1024, 16384.
// - Upper rail within trip level enters holdover.
// - Tracking count field resets to 127.
// - DAC steps every multiplier times count ticks.
// - Force bit locks manual input exclusively.
// - Lock detect falling edge makes switch event.
// - Input absent causes holdover entry when enabled.
// - Rail trip marks input invalid, switches.
// - Style bit picks hard or hitless switch.
// - Holdover enable bit gates holdover entirely.
// - Exit after fourteen-bit count of valid ticks.
// - Lower rail trip also enters holdover.
// - Tracking only while locked, starts at 512.
module holdover_entry_exit_control import holdover_pkg::*; (
  input wire logic pclk, // System clock, 250 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB write.
  input wire logic [ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic pdf_tick, // One phase-compare period, pulse.
  input wire logic pdf_valid, // Phase-compare clock valid at tick.
  input wire logic digital_lock_detect, // First loop locked.
  input wire logic input_absent_flag, // Loss of input signal.
  input wire logic [DAC_W-1:0] vtune_code, // Sampled tuning voltage.
  output logic [DAC_W-1:0] tracked_dac, // Tracked DAC value.
  output logic holdover_active, // Holdover mode.
  output logic switch_event, // Clock switch event pulse.
  output logic switch_hitless, // Switch style for the event.
  output logic input_invalid, // Current input marked invalid.
  output logic input_force_exclusive, // Lock onto forced input only.
  output logic [1:0] forced_input, // Input chosen when forced.
  output logic irq // Level interrupt.
);
  logic [7:0] mult_trip_reg;
  logic [7:0] rate_count_reg;
  switch_cfg_s switch_reg;
  logic [7:0] exit_high_reg;
  logic [7:0] exit_low_reg;
  logic [7:0] control_reg;
  logic [7:0] low_trip_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_status_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [31:0] prdata_reg;
  logic [DAC_W-1:0] dac_reg;
  logic [DAC_W-1:0] dac_next;
  hold_state_e state_reg;
  hold_state_e state_next;
  logic [EXIT_W-1:0] exit_cnt_reg;
  logic [EXIT_W-1:0] exit_cnt_next;
  logic dld_prev_reg;
  logic absent_prev_reg;
  logic rail_prev_reg;
  logic invalid_reg;
  logic switch_reg_out;
  switch_cause_s cause;
  logic step;
  logic reload_reg;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [9:0] idx);
    hit = (a == byte_addr(idx));
  endfunction

  // APB decode.
  wire wr = psel && penable && pwrite;
  wire setup_rd = psel && !penable && !pwrite;
  wire rd_done = psel && penable && !pwrite;
  wire h_mt = hit(paddr, IDX_MULT_TRIP);
  wire h_rc = hit(paddr, IDX_RATE_COUNT);
  wire h_sw = hit(paddr, IDX_SWITCH_EN);
  wire h_eh = hit(paddr, IDX_EXIT_HIGH);
  wire h_el = hit(paddr, IDX_EXIT_LOW);
  wire h_ct = hit(paddr, IDX_CONTROL);
  wire h_lt = hit(paddr, IDX_LOW_TRIP);
  wire h_st = hit(paddr, IDX_STATE);
  wire h_is = hit(paddr, IDX_IRQ_STATUS);
  wire h_im = hit(paddr, IDX_IRQ_MASK);
  wire mapped = h_mt | h_rc | h_sw | h_eh | h_el | h_ct | h_lt | h_st |
    h_is | h_im;

  // Fields.
  wire [1:0] mult_code = mult_trip_reg[MULT_LSB+1:MULT_LSB];
  wire [5:0] upper_trip = mult_trip_reg[TRIP_MSB:0];
  wire [5:0] lower_trip = low_trip_reg[TRIP_MSB:0];
  wire track_enable = control_reg[CTRL_TRACK_BIT];
  wire [2:0] input_select_policy = control_reg[CTRL_POLICY_LSB+2:
    CTRL_POLICY_LSB];
  wire [EXIT_W-1:0] hold_exit_valid_count =
    {exit_high_reg[TRIP_MSB:0], exit_low_reg};

  // Multiplier is four times sixteen to the power of code.
  wire [MULT_W-1:0] tracking_rate_multiplier =
    MULT_W'(4) << {mult_code, 2'b00};
  wire [PERIOD_W-1:0] interval = PERIOD_W'(tracking_rate_multiplier) *
    PERIOD_W'(rate_count_reg);

  // Reload one cycle after the write, once the new field is stored.
  step_interval_timer #(.PERIOD_W(PERIOD_W)) step_interval_timer_inst (
    .pclk(pclk),
    .presetn(presetn),
    .tick(pdf_tick),
    .reload(reload_reg),
    .period(interval),
    .step(step)
  );

  // Upper trip sits (code+1)/64 of full scale below the top.
  wire [DAC_W-1:0] upper_level = DAC_W'(~DAC_W'(0) -
    DAC_W'((upper_trip + 7'd1) * TRIP_STEP) + DAC_W'(1));
  // Lower trip sits (code+1)/64 of full scale above ground.
  // Kept one bit wider so the top code reaches the full scale.
  wire [DAC_W:0] lower_level = (DAC_W+1)'((lower_trip + 7'd1) * TRIP_STEP);
  wire rail_hit = (dac_reg >= upper_level) ||
    ({1'b0, dac_reg} <= lower_level);

  // Falling lock detect is a lock loss.
  assign cause.lock_loss = switch_reg.lock_loss_switch_enable &&
    dld_prev_reg && !digital_lock_detect;
  assign cause.input_absent = switch_reg.input_absent_switch_enable &&
    input_absent_flag && !absent_prev_reg;
  assign cause.rail = switch_reg.tuning_rail_switch_enable &&
    rail_hit && !rail_prev_reg;
  wire any_event = |cause;

  // Entry only when holdover is enabled.
  wire enter = (state_reg == HOLD_IDLE) && any_event &&
    switch_reg.holdover_enable;
  // A missing or invalid clock breaks the run.
  wire run_broken = pdf_tick && (!pdf_valid || input_absent_flag);
  // Exit when the unbroken run reaches the count.
  wire leave = (state_reg == HOLD_ACTIVE) && pdf_tick && !run_broken &&
    (exit_cnt_reg + EXIT_W'(1) >= hold_exit_valid_count);

  always_comb begin
    state_next = state_reg;
    exit_cnt_next = exit_cnt_reg;
    case (state_reg)
      HOLD_IDLE: begin
        exit_cnt_next = '0;
        if (enter) begin
          state_next = HOLD_ACTIVE;
        end
      end
      HOLD_ACTIVE: begin
        if (!switch_reg.holdover_enable || leave) begin
          state_next = HOLD_IDLE;
          exit_cnt_next = '0;
        end else if (run_broken) begin
          exit_cnt_next = '0;
        end else if (pdf_tick) begin
          exit_cnt_next = exit_cnt_reg + EXIT_W'(1);
        end
      end
      default: begin
        state_next = HOLD_IDLE;
        exit_cnt_next = '0;
      end
    endcase
  end

  // Track toward the tuning voltage only while locked.
  wire track_go = step && track_enable && digital_lock_detect &&
    (state_reg == HOLD_IDLE);
  assign dac_next = !track_go ? dac_reg :
    (vtune_code > dac_reg) ? dac_reg + DAC_W'(1) :
    (vtune_code < dac_reg) ? dac_reg - DAC_W'(1) : dac_reg;

  // Hardware sets win over a read clear in the same cycle.
  wire [IRQ_W-1:0] irq_set = {cause.rail, leave, enter, any_event};
  // Only the bits returned by the read are cleared, so a bit set at the
  // setup edge is not lost unseen.
  assign irq_status_next = ((rd_done && h_is) ?
    (irq_status_reg & ~prdata_reg[IRQ_W-1:0]) : irq_status_reg) | irq_set;

  wire [31:0] rd_mux =
    h_mt ? {24'h0000_00, mult_trip_reg} :
    h_rc ? {24'h0000_00, rate_count_reg} :
    h_sw ? {24'h0000_00, switch_reg & 8'h5f} :
    h_eh ? {26'h000_0000, exit_high_reg[TRIP_MSB:0]} :
    h_el ? {24'h0000_00, exit_low_reg} :
    h_ct ? {24'h0000_00, control_reg} :
    h_lt ? {26'h000_0000, low_trip_reg[TRIP_MSB:0]} :
    h_st ? {20'h0000_0, invalid_reg, state_reg == HOLD_ACTIVE, dac_reg} :
    h_is ? {28'h000_0000, irq_status_reg} :
    h_im ? {28'h000_0000, irq_mask_reg} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mult_trip_reg <= RST_MULT_TRIP;
      rate_count_reg <= RST_RATE_COUNT;
      switch_reg <= RST_SWITCH_EN;
      exit_high_reg <= RST_EXIT_HIGH;
      exit_low_reg <= RST_EXIT_LOW;
      control_reg <= RST_CONTROL;
      low_trip_reg <= RST_LOW_TRIP;
      irq_mask_reg <= '0;
    end else if (wr) begin
      if (h_mt) mult_trip_reg <= pwdata[7:0];
      // Full 0 to 255 count range.
      if (h_rc) rate_count_reg <= pwdata[7:0];
      if (h_sw) switch_reg <= pwdata[7:0] & 8'h5f;
      if (h_eh) exit_high_reg <= {2'b00, pwdata[TRIP_MSB:0]};
      if (h_el) exit_low_reg <= pwdata[7:0];
      if (h_ct) control_reg <= {4'h0, pwdata[3:0]};
      if (h_lt) low_trip_reg <= {2'b00, pwdata[TRIP_MSB:0]};
      if (h_im) irq_mask_reg <= pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= HOLD_IDLE;
      exit_cnt_reg <= '0;
      dac_reg <= DAC_START;
      dld_prev_reg <= 1'b0;
      absent_prev_reg <= 1'b0;
      rail_prev_reg <= 1'b0;
      invalid_reg <= 1'b0;
      switch_reg_out <= 1'b0;
      irq_status_reg <= '0;
      prdata_reg <= '0;
      reload_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      exit_cnt_reg <= exit_cnt_next;
      dac_reg <= dac_next;
      dld_prev_reg <= digital_lock_detect;
      absent_prev_reg <= input_absent_flag;
      rail_prev_reg <= rail_hit;
      // Input stays invalid until holdover exits on the valid-tick count; leaving by clearing the enable keeps it set.
      invalid_reg <= cause.rail || (invalid_reg && !leave);
      switch_reg_out <= any_event;
      irq_status_reg <= irq_status_next;
      if (setup_rd) prdata_reg <= rd_mux;
      reload_reg <= wr && (h_mt || h_rc);
    end
  end

  // APB: no wait states, read data is registered in the setup cycle.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;
  assign tracked_dac = dac_reg;
  assign holdover_active = (state_reg == HOLD_ACTIVE);
  assign switch_event = switch_reg_out;
  // Hitless needs no completion bound, so it is only a level.
  assign switch_hitless = switch_reg.hitless_switch;
  assign input_invalid = invalid_reg;
  // Manual policies 0 to 2 with force set.
  assign input_force_exclusive = switch_reg.manual_input_force &&
    (input_select_policy < POLICY_AUTO_MIN);
  assign forced_input = input_select_policy[1:0];
  assign irq = |(irq_status_reg & irq_mask_reg);

  a_lock_loss_event: assert property (@(posedge pclk) disable iff (!presetn)
    (switch_reg.lock_loss_switch_enable && $fell(digital_lock_detect))
    |-> ##1 switch_event)
    else $error("lock loss gave no switch event");
  a_no_event_off: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(digital_lock_detect) && !switch_reg.input_absent_switch_enable &&
     !switch_reg.tuning_rail_switch_enable &&
     !switch_reg.lock_loss_switch_enable) |-> ##1 !switch_event)
    else $error("switch event while all enables are off");
  a_absent_entry: assert property (@(posedge pclk) disable iff (!presetn)
    (!holdover_active && switch_reg.holdover_enable &&
     switch_reg.input_absent_switch_enable && $rose(input_absent_flag))
    |=> holdover_active)
    else $error("signal loss did not enter holdover");
  a_hold_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    !switch_reg.holdover_enable |=> !holdover_active)
    else $error("holdover active while disabled");
  a_exit_count: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(holdover_active) && $past(switch_reg.holdover_enable))
    |-> $past(exit_cnt_reg) + 1 >= $past(hold_exit_valid_count))
    else $error("holdover left before the valid count");
  a_run_restart: assert property (@(posedge pclk) disable iff (!presetn)
    (holdover_active && pdf_tick && !pdf_valid) |=> exit_cnt_reg == 0)
    else $error("exit counter kept a broken run");
  a_track_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    (!digital_lock_detect || holdover_active) |=> $stable(tracked_dac))
    else $error("DAC moved while unlocked or in holdover");
  a_force_select: assert property (@(posedge pclk) disable iff (!presetn)
    input_force_exclusive |-> (switch_reg.manual_input_force &&
    forced_input != 2'b11 && !control_reg[CTRL_POLICY_LSB+2]))
    else $error("force output without a manual policy");
  a_rail_invalid: assert property (@(posedge pclk) disable iff (!presetn)
    cause.rail |=> input_invalid && switch_event)
    else $error("rail trip did not invalidate the input");
endmodule
`default_nettype wire

// [src/holdover_pkg.sv]
// Constants, register map and carrier types for the holdover control block.
package holdover_pkg;

  localparam int ADDR_W = 12;
  localparam int DAC_W = 10;
  localparam int EXIT_W = 14;
  localparam int MULT_W = 15;
  localparam int PERIOD_W = 23;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_MULT_TRIP = 10'h14e;
  localparam logic [9:0] IDX_RATE_COUNT = 10'h14f;
  localparam logic [9:0] IDX_SWITCH_EN = 10'h150;
  localparam logic [9:0] IDX_EXIT_HIGH = 10'h151;
  localparam logic [9:0] IDX_EXIT_LOW = 10'h152;
  localparam logic [9:0] IDX_CONTROL = 10'h1f0;
  localparam logic [9:0] IDX_LOW_TRIP = 10'h1f1;
  localparam logic [9:0] IDX_STATE = 10'h1f2;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h1f3;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h1f4;

  // Field positions.
  localparam int MULT_LSB = 6;
  localparam int TRIP_MSB = 5;
  localparam int CTRL_TRACK_BIT = 0;
  localparam int CTRL_POLICY_LSB = 1;
  localparam int STATE_HOLD_BIT = 10;
  localparam int STATE_INVALID_BIT = 11;

  // Reset values.
  localparam logic [7:0] RST_MULT_TRIP = 8'h00;
  localparam logic [7:0] RST_RATE_COUNT = 8'h7f;
  localparam logic [7:0] RST_SWITCH_EN = 8'h03;
  localparam logic [7:0] RST_EXIT_HIGH = 8'h02;
  localparam logic [7:0] RST_EXIT_LOW = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h01;
  localparam logic [7:0] RST_LOW_TRIP = 8'h00;
  localparam logic [DAC_W-1:0] DAC_START = 10'h200;
  localparam logic [DAC_W-1:0] TRIP_STEP = 10'h010;
  localparam logic [2:0] POLICY_AUTO_MIN = 3'h3;

  // Interrupt status bit positions.
  localparam int IRQ_SWITCH = 0;
  localparam int IRQ_ENTER = 1;
  localparam int IRQ_EXIT = 2;
  localparam int IRQ_RAIL = 3;
  localparam int IRQ_W = 4;

  typedef enum logic {HOLD_IDLE, HOLD_ACTIVE} hold_state_e;

  typedef struct packed {
    logic reserved7;
    logic manual_input_force;
    logic reserved5;
    logic lock_loss_switch_enable;
    logic input_absent_switch_enable;
    logic tuning_rail_switch_enable;
    logic hitless_switch;
    logic holdover_enable;
  } switch_cfg_s;

  typedef struct packed {
    logic lock_loss;
    logic input_absent;
    logic rail;
  } switch_cause_s;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [9:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

endpackage

// [src/step_interval_timer.sv]
// Down counter that issues one step request per programmed tick interval.
`timescale 1ns/1ps
`default_nettype none
module step_interval_timer #(
  parameter int PERIOD_W = 23
) (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic tick, // One phase-compare period elapsed.
  input wire logic reload, // Interval fields were rewritten.
  input wire logic [PERIOD_W-1:0] period, // Interval in ticks.
  output logic step // One-cycle step request.
);
  logic [PERIOD_W-1:0] count_reg;
  logic [PERIOD_W-1:0] count_next;
  logic step_reg;
  wire expire = tick && (count_reg <= PERIOD_W'(1));

  assign count_next = (reload || expire) ? period :
    (tick ? count_reg - PERIOD_W'(1) : count_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
      step_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      step_reg <= expire && !reload;
    end
  end

  assign step = step_reg;
endmodule
`default_nettype wire

// [sim/holdover_entry_exit_control_tb_top.sv]
// Self-checking bench for the holdover entry and exit control block.
`timescale 1ns/1ps
`default_nettype none
module holdover_entry_exit_control_tb_top import holdover_pkg::*; ;
  localparam logic [9:0] RIDX [0:8] = '{IDX_MULT_TRIP, IDX_RATE_COUNT,
    IDX_SWITCH_EN, IDX_EXIT_HIGH, IDX_EXIT_LOW, IDX_CONTROL, IDX_LOW_TRIP,
    IDX_IRQ_MASK, IDX_IRQ_STATUS};
  localparam logic [7:0] RVAL [0:8] = '{RST_MULT_TRIP, RST_RATE_COUNT,
    RST_SWITCH_EN, RST_EXIT_HIGH, RST_EXIT_LOW, RST_CONTROL, RST_LOW_TRIP,
    8'h00, 8'h00};
  localparam logic [7:0] EN_T [0:2] = '{8'h10, 8'h01, 8'h09};
  localparam logic EV_T [0:2] = '{1'b1, 1'b0, 1'b1};
  localparam logic HO_T [0:2] = '{1'b0, 1'b0, 1'b1};
  localparam logic [9:0] RX_T [0:3] = '{IDX_MULT_TRIP, IDX_MULT_TRIP,
    IDX_LOW_TRIP, IDX_LOW_TRIP};
  localparam logic [7:0] RV_T [0:3] = '{8'd30, 8'd31, 8'd31, 8'd32};
  localparam logic EV_R [0:3] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic pdf_tick = 1'b0;
  logic pdf_valid = 1'b0;
  logic digital_lock_detect = 1'b0;
  logic input_absent_flag = 1'b0;
  logic [DAC_W-1:0] vtune_code = DAC_START;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [DAC_W-1:0] tracked_dac;
  logic holdover_active;
  logic switch_event;
  logic switch_hitless;
  logic input_invalid;
  logic input_force_exclusive;
  logic [1:0] forced_input;
  logic irq;
  logic [DAC_W-1:0] exp_dac = DAC_START;
  logic [32:0] exp_q [$];
  int seed = 32'h5410;
  int failures = 0;
  int check_count = 0;
  int i;
  int rnd;
  int m;
  int cnt;

  holdover_entry_exit_control holdover_entry_exit_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pdf_tick(pdf_tick),
    .pdf_valid(pdf_valid), .digital_lock_detect(digital_lock_detect),
    .input_absent_flag(input_absent_flag), .vtune_code(vtune_code),
    .tracked_dac(tracked_dac), .holdover_active(holdover_active),
    .switch_event(switch_event), .switch_hitless(switch_hitless),
    .input_invalid(input_invalid),
    .input_force_exclusive(input_force_exclusive),
    .forced_input(forced_input), .irq(irq));

  always #2 pclk = ~pclk;

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Each transfer starts on an edge, so back-to-back calls leave one idle cycle.
  task automatic apb(input logic wr, input logic [9:0] idx,
      input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [7:0] v,
      input logic err);
    exp_q.push_back({err, 24'h00_0000, v});
    apb(1'b0, idx, 8'h00);
  endtask

  task automatic ticks(input int n, input logic v);
    repeat (n) begin
      @(posedge pclk);
      pdf_tick <= 1'b1;
      pdf_valid <= v;
      @(posedge pclk);
      pdf_tick <= 1'b0;
    end
  endtask

  // Three edges let a registered step or state change land before a compare.
  task automatic wait3();
    repeat (3) @(posedge pclk);
    #1;
  endtask

  task automatic wait_ev(input logic e);
    logic seen;
    seen = 1'b0;
    repeat (4) begin
      @(posedge pclk);
      #1;
      if (switch_event === 1'b1) seen = 1'b1;
    end
    check(33'(seen), 33'(e));
  endtask

  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 &&
        pwrite === 1'b0 && exp_q.size() > 0) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
  end

  initial begin
    #300000;
    failures++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 9; i++) rd(RIDX[i], RVAL[i], 1'b0);
    rd(10'h100, 8'h00, 1'b1);
    check(33'(switch_hitless), 33'h0_0000_0001);
    for (i = 0; i < 5; i += 4) begin
      rnd = $random(seed);
      wr(RIDX[i], rnd[7:0]);
      rd(RIDX[i], rnd[7:0], 1'b0);
    end
    @(posedge pclk);
    digital_lock_detect <= 1'b1;
    rnd = $random(seed);
    vtune_code <= {2'b11, rnd[7:0]};
    for (i = 0; i < 5; i++) begin
      cnt = (i == 4) ? 3 : 1;
      m = (4 << (4 * (i % 4))) * cnt;
      wr(IDX_MULT_TRIP, 8'((i % 4) << 6));
      wr(IDX_RATE_COUNT, 8'(cnt));
      ticks(m - 1, 1'b1);
      wait3();
      check(33'(tracked_dac), 33'(exp_dac));
      ticks(1, 1'b1);
      wait3();
      exp_dac++;
      check(33'(tracked_dac), 33'(exp_dac));
    end
    wr(IDX_CONTROL, 8'h00);
    ticks(12, 1'b1);
    wait3();
    check(33'(tracked_dac), 33'(exp_dac));
    wr(IDX_SWITCH_EN, 8'he3);
    rd(IDX_SWITCH_EN, 8'h43, 1'b0);
    wr(IDX_CONTROL, 8'h02);
    wait3();
    check(33'({input_force_exclusive, forced_input}), 33'h0_0000_0005);
    wr(IDX_CONTROL, 8'h06);
    wait3();
    check(33'(input_force_exclusive), 33'h0_0000_0000);
    wr(IDX_EXIT_HIGH, 8'h00);
    wr(IDX_EXIT_LOW, 8'h03);
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_SWITCH_EN, 8'h11);
    wait3();
    check(33'(switch_hitless), 33'h0_0000_0000);
    @(posedge pclk);
    digital_lock_detect <= 1'b0;
    @(posedge pclk);
    #1;
    check(33'({switch_event, holdover_active, irq}), 33'h0_0000_0007);
    @(posedge pclk);
    #1;
    check(33'(switch_event), 33'h0_0000_0000);
    rd(IDX_IRQ_STATUS, 8'h03, 1'b0);
    wait3();
    check(33'(irq), 33'h0_0000_0000);
    ticks(2, 1'b1);
    ticks(1, 1'b0);
    ticks(2, 1'b1);
    wait3();
    check(33'(holdover_active), 33'h0_0000_0001);
    ticks(1, 1'b1);
    wait3();
    check(33'(holdover_active), 33'h0_0000_0000);
    rd(IDX_IRQ_STATUS, 8'h04, 1'b0);
    @(posedge pclk);
    digital_lock_detect <= 1'b1;
    for (i = 0; i < 3; i++) begin
      wr(IDX_SWITCH_EN, EN_T[i]);
      @(posedge pclk);
      digital_lock_detect <= (i != 0);
      input_absent_flag <= (i != 0);
      wait_ev(EV_T[i]);
      check(33'(holdover_active), 33'(HO_T[i]));
      @(posedge pclk);
      digital_lock_detect <= 1'b1;
      input_absent_flag <= 1'b0;
      ticks(3, 1'b1);
    end
    wr(IDX_SWITCH_EN, 8'h05);
    for (i = 0; i < 4; i++) begin
      wr(RX_T[i], RV_T[i]);
      wait_ev(EV_R[i]);
      check(33'({input_invalid, holdover_active}), 33'({2{EV_R[i]}}));
      ticks(3, 1'b1);
      wait3();
      check(33'(input_invalid), 33'h0_0000_0000);
      wr(IDX_MULT_TRIP, 8'h00);
      wr(IDX_LOW_TRIP, 8'h00);
    end
    check(33'(exp_q.size()), 33'h0_0000_0000);
    summarize();
  end
endmodule
`default_nettype wire
